// ---- scpc_top.sv ----
// scpc_top: serial configuration pin control with an axi4-lite register slave
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module scpc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic config_clock_in, // clock pad level
    output logic config_clock_out, // driven level in active mode
    output logic config_clock_oe_n, // low while driving the clock
    input wire logic serial_config_in, // serial data pin
    input wire logic user_startup_clock, // optional start-up clock
    input wire logic config_request_n, // low requests a reload
    input wire logic global_output_enable, // optional output enable
    input wire logic global_clear_n, // optional device-wide clear
    input wire logic init_complete_flag_in, // pad level, unused
    output logic init_complete_flag_out, // open-drain, low when driven
    output logic init_complete_flag_oe_n, // low while pulling low
    output logic load_complete, // all words received
    output logic io_force_hiz, // float user i/o
    output logic reg_clear_n, // low clears user registers
    output logic [3:0] weak_pullup_en // usrclk, init, oe, clr
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [5:0] pins_s; // synchronised pins
    logic cclk_s, din_s, uclk_s; // synchronised clocks and data
    logic req_n_s, goe_s, gclr_n_s; // synchronised levels
    logic cclk_prev_q, uclk_prev_q; // last clock samples, for edges

    scpc_sync #(.W(6)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({config_clock_in, serial_config_in, user_startup_clock,
                   config_request_n, global_output_enable, global_clear_n}),
        .sync_out(pins_s)
    );
    assign {cclk_s, din_s, uclk_s, req_n_s, goe_s, gclr_n_s} = pins_s;
    // edge history of the clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cclk_prev_q <= 1'b0;
            uclk_prev_q <= 1'b0;
        end else begin
            cclk_prev_q <= cclk_s;
            uclk_prev_q <= uclk_s;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // registers and state
    scpc_pkg::scpc_state_e state_q; // load sequencer
    logic [31:0] ctrl_q; // mode select
    logic [31:0] length_q; // words expected, option word included
    logic [scpc_pkg::OPT_W-1:0] opt_q; // options from the first word
    logic opt_valid_q; // first word has been loaded
    logic overflow_q; // a passive word was lost on a full fifo
    logic [4:0] bit_cnt_q; // bit within the current word
    logic [31:0] shift_q; // assembling word
    logic [31:0] words_q; // words received
    logic [3:0] init_cnt_q; // start-up ticks spent initializing
    logic [7:0] as_div_q; // active clock half-period counter
    logic as_clk_q; // active clock level
    logic [7:0] int_div_q; // internal start-up clock divider
    logic int_tick, startup_tick, as_half; // timing strobes
    logic mode_as, shift_en, word_done; // mode, bit taken, word complete
    logic fifo_in_ready, fifo_out_valid, fifo_pop; // fifo handshakes
    logic [31:0] fifo_out_data; // word at the fifo head
    assign mode_as = ctrl_q[scpc_pkg::CTRL_MODE_AS_BIT];
    assign as_half = (as_div_q == 8'(scpc_pkg::AS_HALF_CYC - 1));
    // passive: pin rise during load; active: our own clock rise
    assign shift_en = (state_q == scpc_pkg::ST_LOAD) && (mode_as ?
        (as_half && !as_clk_q && fifo_in_ready) : (cclk_s && !cclk_prev_q));
    assign word_done = shift_en && (bit_cnt_q == scpc_pkg::LAST_BIT);
    assign int_tick = (int_div_q == 8'(scpc_pkg::INT_TICK_CYC - 1));
    // start-up timing source
    assign startup_tick = opt_q[scpc_pkg::OPT_USRCLK_BIT] ?
        (uclk_s && !uclk_prev_q) : int_tick;
    // internal start-up divider, free running
    always_ff @(posedge aclk) begin
        if (!aresetn || int_tick) begin
            int_div_q <= '0;
        end else begin
            int_div_q <= int_div_q + 8'h01;
        end
    end
    // active clock, stalls low on a full fifo
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q != scpc_pkg::ST_LOAD || !mode_as) begin
            as_div_q <= '0;
            as_clk_q <= 1'b0;
        end else if (as_half) begin
            if (as_clk_q || fifo_in_ready) begin
                as_clk_q <= !as_clk_q;
                as_div_q <= '0;
            end
        end else begin
            as_div_q <= as_div_q + 8'h01;
        end
    end
    // bit assembly, msb first
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q == scpc_pkg::ST_IDLE) begin
            shift_q <= '0;
            bit_cnt_q <= '0;
        end else if (shift_en) begin
            shift_q <= {shift_q[30:0], din_s};
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end
    // word count and options
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q == scpc_pkg::ST_IDLE) begin
            words_q <= '0;
            opt_q <= '0;
            opt_valid_q <= 1'b0;
        end else if (word_done) begin
            words_q <= words_q + 32'h0000_0001;
            if (!opt_valid_q) begin
                opt_q <= {shift_q[2:0], din_s};
                opt_valid_q <= 1'b1;
            end
        end
    end
    // load sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= scpc_pkg::ST_IDLE;
            init_cnt_q <= '0;
        end else if (!req_n_s) begin
            state_q <= scpc_pkg::ST_IDLE;
            init_cnt_q <= '0;
        end else begin
            case (state_q)
                scpc_pkg::ST_IDLE: begin
                    state_q <= scpc_pkg::ST_LOAD;
                end
                scpc_pkg::ST_LOAD: begin
                    if (words_q >= length_q) begin // all words in
                        state_q <= scpc_pkg::ST_INIT;
                    end
                end
                scpc_pkg::ST_INIT: begin
                    if (startup_tick) begin
                        if (init_cnt_q == scpc_pkg::INIT_TICKS - 4'h1) begin
                            state_q <= scpc_pkg::ST_USER;
                        end
                        init_cnt_q <= init_cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= scpc_pkg::ST_USER;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs; load_complete stays up until the next request
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q == scpc_pkg::ST_IDLE) begin
            load_complete <= 1'b0;
        end else if (state_q == scpc_pkg::ST_LOAD && words_q >= length_q) begin
            load_complete <= 1'b1;
        end
    end
    // pin drives and user i/o controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_clock_out <= 1'b0;
            config_clock_oe_n <= 1'b1;
            init_complete_flag_oe_n <= 1'b1;
            io_force_hiz <= 1'b0;
            reg_clear_n <= 1'b1;
            weak_pullup_en <= 4'hF;
        end else begin
            config_clock_out <= as_clk_q;
            // released whenever not actively loading
            config_clock_oe_n <= !(mode_as && state_q == scpc_pkg::ST_LOAD);
            init_complete_flag_oe_n <= !(opt_valid_q && opt_q[scpc_pkg::OPT_INIT_BIT]
                && (state_q == scpc_pkg::ST_LOAD || state_q == scpc_pkg::ST_INIT));
            io_force_hiz <= (state_q == scpc_pkg::ST_USER)
                && opt_q[scpc_pkg::OPT_OE_BIT] && !goe_s;
            reg_clear_n <= !((state_q == scpc_pkg::ST_USER)
                && opt_q[scpc_pkg::OPT_CLR_BIT] && !gclr_n_s);
            weak_pullup_en <= (state_q == scpc_pkg::ST_USER) ? 4'h0 : ~opt_q;
        end
    end
    assign init_complete_flag_out = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // word buffer between the link and software
    scpc_fifo #(.WIDTH(scpc_pkg::WORD_W), .DEPTH(scpc_pkg::FIFO_DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(state_q == scpc_pkg::ST_IDLE),
        .in_valid(word_done),
        .in_ready(fifo_in_ready),
        .in_data({shift_q[30:0], din_s}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    logic aw_have_q, w_have_q; // halves taken
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic do_write, ovf_clear;
    assign awready = !aw_have_q && !bvalid;
    assign wready = !w_have_q && !bvalid;
    assign do_write = aw_have_q && w_have_q && !bvalid;
    assign ovf_clear = do_write && aw_addr_q == scpc_pkg::ADDR_STATUS
        && w_data_q[scpc_pkg::ST_OVERFLOW_BIT];
    // capture address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end
    // register writes, response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= scpc_pkg::CTRL_RST;
            length_q <= scpc_pkg::LENGTH_RST;
            bvalid <= 1'b0;
            bresp <= scpc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= scpc_pkg::RESP_OKAY;
            if (aw_addr_q == scpc_pkg::ADDR_CTRL) begin
                ctrl_q <= w_data_q;
            end else if (aw_addr_q == scpc_pkg::ADDR_LENGTH) begin
                length_q <= w_data_q;
            end else if (aw_addr_q != scpc_pkg::ADDR_STATUS) begin
                bresp <= scpc_pkg::RESP_SLVERR;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
    // sticky overflow; a new loss beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q == scpc_pkg::ST_IDLE) begin
            overflow_q <= 1'b0;
        end else if (word_done && !fifo_in_ready) begin
            overflow_q <= 1'b1;
        end else if (ovf_clear) begin
            overflow_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel, one cycle answer
    logic [31:0] status_w;
    assign arready = !rvalid;
    assign fifo_pop = arvalid && arready && araddr == scpc_pkg::ADDR_DATA;
    always_comb begin
        status_w = '0;
        status_w[scpc_pkg::ST_STATE_LSB +: 2] = state_q;
        status_w[scpc_pkg::ST_LOAD_DONE_BIT] = load_complete;
        status_w[scpc_pkg::ST_USER_BIT] = (state_q == scpc_pkg::ST_USER);
        status_w[scpc_pkg::ST_OVERFLOW_BIT] = overflow_q;
        status_w[scpc_pkg::ST_FIFO_VALID_BIT] = fifo_out_valid;
        status_w[scpc_pkg::ST_WORDS_LSB +: 16] = words_q[15:0];
    end
    // read data decode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= scpc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= scpc_pkg::RESP_OKAY;
            if (araddr == scpc_pkg::ADDR_CTRL) begin
                rdata <= ctrl_q;
            end else if (araddr == scpc_pkg::ADDR_LENGTH) begin
                rdata <= length_q;
            end else if (araddr == scpc_pkg::ADDR_STATUS) begin
                rdata <= status_w;
            end else if (araddr == scpc_pkg::ADDR_DATA) begin
                rdata <= fifo_out_valid ? fifo_out_data : '0;
            end else if (araddr == scpc_pkg::ADDR_OPTIONS) begin
                rdata <= {28'h000_0000, opt_q};
            end else begin
                rdata <= '0;
                rresp <= scpc_pkg::RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// ---- scpc_pkg.sv ----
// scpc_pkg: shared constants for the serial configuration pin control block
package scpc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LENGTH = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_OPTIONS = 8'h10;
    // ctrl register fields
    localparam int CTRL_MODE_AS_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LENGTH_RST = 32'h0000_0010;
    // status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_LOAD_DONE_BIT = 2;
    localparam int ST_USER_BIT = 3;
    localparam int ST_OVERFLOW_BIT = 4;
    localparam int ST_FIFO_VALID_BIT = 5;
    localparam int ST_WORDS_LSB = 8;
    // option bits in the first word
    localparam int OPT_USRCLK_BIT = 0;
    localparam int OPT_INIT_BIT = 1;
    localparam int OPT_OE_BIT = 2;
    localparam int OPT_CLR_BIT = 3;
    localparam int OPT_W = 4;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // stream geometry
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] LAST_BIT = 5'h1F;
    // timing in picoseconds
    localparam int CLK_PERIOD_PS = 5000;
    localparam int AS_HALF_PS = 20000;
    localparam int INT_OSC_PS = 100000;
    localparam int AS_HALF_CYC = (AS_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INT_TICK_CYC = (INT_OSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // start-up ticks in initialization
    localparam logic [3:0] INIT_TICKS = 4'h8;
    // load sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_INIT,
        ST_USER
    } scpc_state_e;
endpackage

// ---- scpc_sync.sv ----
// scpc_sync: two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module scpc_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q; // first stage, read only by the second
    ////////////////////////////////////////////////////////////////////////
    // two stages, cleared by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- scpc_fifo.sv ----
// scpc_fifo: small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module scpc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage array
    logic [AW-1:0] wr_q; // write pointer
    logic [AW-1:0] rd_q; // read pointer
    logic [AW:0] cnt_q; // occupancy
    logic push;
    logic pop;
    // honest full and empty
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    ////////////////////////////////////////////////////////////////////////
    // storage write
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    // pointers and count
    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end
endmodule

// ---- scpc_top_props.sv ----
// scpc_top_props: concurrent checks on the pin control ports
`timescale 1ns/1ps
module scpc_top_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic config_request_n,
    input wire logic config_clock_out,
    input wire logic config_clock_oe_n,
    input wire logic init_complete_flag_out,
    input wire logic init_complete_flag_oe_n,
    input wire logic load_complete,
    input wire logic io_force_hiz,
    input wire logic reg_clear_n,
    input wire logic [3:0] weak_pullup_en
);
    // one clock domain, reset disables every check
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_flag_idle: assert property (
        !config_request_n [*6] |-> init_complete_flag_oe_n && !load_complete
    ) else $error("init flag not released while idle");
    chk_pull_idle: assert property (
        !config_request_n [*6] |-> weak_pullup_en == 4'hF
    ) else $error("pull-ups off while idle");
    chk_open_drain: assert property (
        init_complete_flag_oe_n || !init_complete_flag_out
    ) else $error("init flag driven high");
    chk_flag_release: assert property (
        $rose(init_complete_flag_oe_n) && config_request_n |-> load_complete
    ) else $error("init flag released before load end");
    chk_clk_half: assert property (
        $rose(config_clock_out) && !config_clock_oe_n |->
            (config_clock_out || config_clock_oe_n) [*4]
    ) else $error("active clock high phase too short");
    chk_clk_release: assert property (
        $rose(load_complete) |-> ##[0:2] config_clock_oe_n
    ) else $error("clock pin still driven after load");
    chk_hiz_option: assert property (
        io_force_hiz |-> !weak_pullup_en[2]
    ) else $error("hi-z forced with option off");
    chk_clear_option: assert property (
        !reg_clear_n |-> !weak_pullup_en[3]
    ) else $error("clear applied with option off");
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
endmodule
bind scpc_top scpc_top_props u_props (.aclk, .aresetn, .bvalid, .bready, .bresp, .rvalid,
    .rready, .rdata, .config_request_n, .config_clock_out, .config_clock_oe_n,
    .init_complete_flag_out, .init_complete_flag_oe_n, .load_complete, .io_force_hiz,
    .reg_clear_n, .weak_pullup_en);

// ---- scpc_cfg_mem.sv ----
// scpc_cfg_mem: serial configuration source model, host or memory
`timescale 1ns/1ps
module scpc_cfg_mem (
    input wire logic start,
    input wire logic active,
    input wire logic config_clock_out,
    input wire logic config_clock_oe_n,
    input wire logic [31:0] words [16],
    input wire logic [4:0] nwords,
    output logic config_clock_in,
    output logic serial_config_in
);
    logic host_clk; // clock made by the host in passive mode
    // pad: our drive in active mode, pulled up when released; else the host clock
    assign config_clock_in = active ? (config_clock_oe_n | config_clock_out) : host_clk;
    // one frame, msb first, one bit per clock
    initial begin
        host_clk = 1'b0; // held low outside frames
        serial_config_in = 1'b1;
        forever begin
            @(posedge start);
            for (int w = 0; w < nwords; w++) begin
                for (int b = 31; b >= 0; b--) begin
                    serial_config_in = words[w][b];
                    if (active) begin
                        @(posedge config_clock_in);
                        #10; // hold past the device sampling
                    end else begin
                        #4 host_clk = 1'b1;
                        #24 host_clk = 1'b0;
                        #20;
                    end
                end
            end
            serial_config_in = ~serial_config_in; // released line shows no stale bit
        end
    end
endmodule

// ---- test_scpc_top.sv ----
// test_scpc_top: self-checking bench for the serial configuration pin control
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_scpc_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, start, active;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, weak_pullup_en;
    logic [1:0] bresp, rresp, rs;
    logic config_clock_in, config_clock_out, config_clock_oe_n, serial_config_in;
    logic user_startup_clock, config_request_n, global_output_enable, global_clear_n;
    logic init_complete_flag_in, init_complete_flag_out, init_complete_flag_oe_n;
    logic load_complete, io_force_hiz, reg_clear_n;
    logic [31:0] words [16];
    logic [4:0] nwords;
    int mismatches, checked, n;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} scpc_row_s;
    // register reads after reset: address, data, response
    scpc_row_s rows [5] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h10, 2'h0},
        '{8'h08, 32'h0, 2'h0}, '{8'h10, 32'h0, 2'h0}, '{8'h14, 32'h0, 2'h2}};
    scpc_top DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .config_clock_in, .config_clock_out, .config_clock_oe_n,
        .serial_config_in, .user_startup_clock, .config_request_n, .global_output_enable,
        .global_clear_n, .init_complete_flag_in, .init_complete_flag_out,
        .init_complete_flag_oe_n, .load_complete, .io_force_hiz, .reg_clear_n,
        .weak_pullup_en);
    scpc_cfg_mem u_mem (.start, .active, .config_clock_out, .config_clock_oe_n, .words,
        .nwords, .config_clock_in, .serial_config_in);
    // open-drain flag with its board pull-up
    assign init_complete_flag_in = init_complete_flag_oe_n | init_complete_flag_out;
    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic end_sim;
        $display("counts: checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // bounded wait for a level
    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            if (s === v) return;
            @(posedge aclk);
        end
        mismatches++;
        end_sim;
    endtask
    // axi4-lite write, both halves at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0; rs = bresp;
        @(posedge aclk);
        if (n == 64) begin mismatches++; end_sim; end
    endtask
    // axi4-lite read
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0; rd = rdata; rs = rresp;
        @(posedge aclk);
        if (n == 64) begin mismatches++; end_sim; end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, start, active, aresetn} = '0;
        {awaddr, araddr, wdata, user_startup_clock, config_request_n} = '0;
        {wstrb, global_output_enable, global_clear_n, nwords} = '1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            rd_reg(rows[i].a);
            `CHK({rs, rd}, {rows[i].r, rows[i].d})
        end
        wr(scpc_pkg::ADDR_DATA, 32'h0); `CHK(rs, scpc_pkg::RESP_SLVERR)
        `CHK({init_complete_flag_oe_n, weak_pullup_en}, 5'h1F)
        $display("test reset_regs done");
        // passive load: 12 words into an 8-word fifo
        words[0] = 32'h0000_0006;
        for (int i = 1; i < 12; i++) words[i] = 32'h5A00_0000 + i;
        nwords <= 5'h0C;
        wr(scpc_pkg::ADDR_LENGTH, 32'h0000_000C);
        config_request_n <= 1'b1;
        repeat (6) @(posedge aclk);
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        wait_for(init_complete_flag_oe_n, 1'b0, 2000); `CHK(load_complete, 1'b0)
        wait_for(load_complete, 1'b1, 5000); `CHK(init_complete_flag_oe_n, 1'b0)
        wait_for(init_complete_flag_oe_n, 1'b1, 400);
        rd_reg(scpc_pkg::ADDR_STATUS); `CHK(rd[4:0], 5'h1F)
        `CHK(weak_pullup_en, 4'h0)
        global_output_enable <= 1'b0; global_clear_n <= 1'b0;
        repeat (6) @(posedge aclk);
        `CHK({io_force_hiz, reg_clear_n}, 2'h3)
        global_output_enable <= 1'b1;
        global_clear_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rd_reg(scpc_pkg::ADDR_STATUS);
            if (!rd[5]) break;
            rd_reg(scpc_pkg::ADDR_DATA);
            `CHK(rd, i ? 32'h5A00_0000 + i : 32'h6)
        end
        rd_reg(scpc_pkg::ADDR_DATA); `CHK(rd, 32'h0)
        wr(scpc_pkg::ADDR_STATUS, 32'h0000_0010); rd_reg(scpc_pkg::ADDR_STATUS);
        `CHK(rd[5:4], 2'h0)
        rd_reg(scpc_pkg::ADDR_OPTIONS); `CHK(rd, 32'h0000_0006)
        $display("test passive_load done");
        // restart, active load timed by start-up clock
        config_request_n <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK({load_complete, init_complete_flag_oe_n, weak_pullup_en}, 6'h1F)
        words[0] = 32'h0000_000B;
        words[1] = 32'hA5A5_5A5A;
        nwords <= 5'h02;
        active <= 1'b1;
        wr(scpc_pkg::ADDR_CTRL, 32'h1); wr(scpc_pkg::ADDR_LENGTH, 32'h2);
        config_request_n <= 1'b1;
        repeat (6) @(posedge aclk);
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        wait_for(config_clock_oe_n, 1'b0, 100);
        wait_for(load_complete, 1'b1, 2000);
        repeat (100) @(posedge aclk);
        `CHK({init_complete_flag_oe_n, config_clock_oe_n}, 2'h1)
        repeat (8) begin
            user_startup_clock <= 1'b1;
            repeat (4) @(posedge aclk);
            user_startup_clock <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        wait_for(init_complete_flag_oe_n, 1'b1, 20);
        global_clear_n <= 1'b0;
        repeat (6) @(posedge aclk);
        `CHK(reg_clear_n, 1'b0)
        rd_reg(scpc_pkg::ADDR_STATUS); `CHK(rd[23:8], 16'h0002)
        $display("test active_load done");
        end_sim;
    end
endmodule
